// [design/cfs_codec_frame_slot.sv]
// Codec frame-sync, sampling-edge, justification and time-slot engine with its buffers.
// Assumes an Avalon-MM master on i_clk; link pins are asynchronous and oversampled.
//
// Behaviour
// - Multi-channel frame starts one bit after sync.
// - Sampled sync pulse resets the frame generator.
// - I2S: either sync edge starts word, resets.
// - AC-link: tag slot starts one bit after sync.
// - Started frame completes; further syncs are ignored.
// - Sample on falling edge, rising when selected.
// - Justify bit starts data in sync period.
// - Sixteen transmit slot enables, slot per word.
// - Enabled transmit slot loads word, advances pointer.
// - Disabled transmit slots drive zero or float.
// - Enables beyond frame length have no effect.
// - Transmit words left-justified, low bits unsent.
// - Sixteen receive slot enables, 1-16 bit slots.
// - Enabled receive slot stores word, advances pointer.
// - Received words stored unpacked, left-justified.
// - Master emits sync when its generator resets.
// - After last slot, wait for next sync.
// - Pointer advances once per enabled slot.
`timescale 1ns/100ps
module cfs_codec_frame_slot
  import cfs_pkg::*;
#(
  parameter int unsigned DEPTH = 4
)
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Codec link
  input wire logic i_serial_bit_clock,
  input wire logic i_frame_sync_pin,
  input wire logic i_serial_data_in,
  output cfs_link_out_t o_link
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  cfs_ctrl_t ctrl_r;
  logic [15:0] tx_mask_r;
  logic [15:0] rx_mask_r;
  logic [15:0] tx_buf_r [DEPTH];
  logic [15:0] rx_buf_r [DEPTH];
  logic [31:0] rdata_r;
  logic wait_r;
  cfs_state_t st_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] slot_cnt_r;
  logic [PTR_W-1:0] ptr_r;
  logic [15:0] tx_sh_r;
  logic [15:0] rx_sh_r;
  logic fs_prev_r;
  cfs_link_out_t link_r;
  logic sck_q1, sck_q2, sck_q3;
  logic fs_q1, fs_q2;
  logic sdi_q1, sdi_q2;

  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic req = i_avs_read | i_avs_write;
  wire logic wr_take = i_ce & i_avs_write & ~wait_r;
  wire logic rd_cap = i_ce & i_avs_read & wait_r;
  wire logic [3:0] buf_idx = i_avs_address[5:2];
  wire logic idx_ok = 32'(buf_idx) < DEPTH;
  wire logic [PTR_W-1:0] buf_sel = PTR_W'(buf_idx);
  wire logic hit_ctrl = i_avs_address == CFS_OFS_CTRL;
  wire logic hit_txm = i_avs_address == CFS_OFS_TX_SLOT;
  wire logic hit_rxm = i_avs_address == CFS_OFS_RX_SLOT;
  wire logic hit_stat = i_avs_address == CFS_OFS_STATUS;
  wire logic hit_txb = (i_avs_address[7:6] == CFS_TXBUF_REGION) & (i_avs_address[1:0] == 2'h0) & idx_ok;
  wire logic hit_rxb = (i_avs_address[7:6] == CFS_RXBUF_REGION) & (i_avs_address[1:0] == 2'h0) & idx_ok;
  wire logic [31:0] stat_word = {20'h00000, 4'(ptr_r), slot_cnt_r, 3'h0, st_r == CFS_ST_RUN};
  wire logic [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_r} :
                             hit_txm ? {16'h0000, tx_mask_r} :
                             hit_rxm ? {16'h0000, rx_mask_r} :
                             hit_stat ? stat_word :
                             hit_txb ? {16'h0000, tx_buf_r[buf_sel]} :
                             hit_rxb ? {16'h0000, rx_buf_r[buf_sel]} : 32'h0000_0000;

  // ----------------------------------------
  // Link edge detection
  // ----------------------------------------
  wire logic sck_rise = sck_q2 & ~sck_q3;
  wire logic sck_fall = ~sck_q2 & sck_q3;
  wire logic samp_edge = i_ce & (ctrl_r.sample_edge_select ? sck_rise : sck_fall);
  wire logic drv_edge = i_ce & (ctrl_r.sample_edge_select ? sck_fall : sck_rise);
  wire logic fs_src = ctrl_r.master ? link_r.frame_sync_pin : fs_q2;
  wire logic is_i2s = ctrl_r.format == CFS_FMT_I2S;
  wire logic fs_seen = is_i2s ? (fs_src ^ fs_prev_r) : fs_src;
  wire logic run = st_r == CFS_ST_RUN;

  // ----------------------------------------
  // Frame and slot sequencing
  // ----------------------------------------
  wire logic start = samp_edge & ~run & ctrl_r.enable & fs_seen;
  wire logic just_start = start & ctrl_r.justify_same_cycle;
  wire logic bit_take = (samp_edge & run) | just_start;
  wire logic [3:0] ws = ctrl_r.word_size_sel;
  wire logic [3:0] cnt_eff = run ? bit_cnt_r : 4'h0;
  wire logic [3:0] slot_eff = run ? slot_cnt_r : 4'h0;
  wire logic [3:0] slot_nxt = 4'(slot_eff + 4'h1);
  wire logic slot_end = bit_take & (cnt_eff == ws);
  wire logic frame_end = slot_end & (slot_eff == ctrl_r.frame_length_sel);
  wire logic tx_en = tx_mask_r[slot_eff];
  wire logic rx_en = rx_mask_r[slot_eff];
  wire logic ptr_adv = slot_end & (tx_en | rx_en);
  wire logic [PTR_W-1:0] ptr_nxt = ptr_adv ? ((ptr_r == PTR_LAST) ? '0 : PTR_W'(ptr_r + 1'b1)) : ptr_r;
  wire logic [15:0] rx_word = {rx_sh_r[14:0], sdi_q2};
  wire logic [15:0] rx_just = 16'(rx_word << (CFS_WS_MAX - ws));
  wire logic tx_load = start | (slot_end & ~frame_end);
  wire logic [15:0] tx_first = tx_mask_r[0] ? tx_buf_r[ptr_r] : 16'h0000;
  wire logic [15:0] tx_next = tx_mask_r[slot_nxt] ? tx_buf_r[ptr_nxt] : 16'h0000;
  wire logic [15:0] tx_word = (start & ~slot_end) ? tx_first : tx_next;
  wire logic next_en = (start & ~slot_end) ? tx_mask_r[0] : (run ? tx_en : 1'b0);
  wire logic fs_gen_set = ~run & ctrl_r.enable & ctrl_r.master & (link_r.frame_sync_pin == fs_prev_r);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      {sck_q1, sck_q2, sck_q3} <= 3'h0;
      {fs_q1, fs_q2, sdi_q1, sdi_q2} <= 4'h0;
    end
    else if (i_ce)
    begin
      {sck_q1, sck_q2, sck_q3} <= {i_serial_bit_clock, sck_q1, sck_q2};
      {fs_q1, fs_q2, sdi_q1, sdi_q2} <= {i_frame_sync_pin, fs_q1, i_serial_data_in, sdi_q1};
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_r <= CFS_CTRL_RST;
      tx_mask_r <= CFS_SLOT_RST;
      rx_mask_r <= CFS_SLOT_RST;
    end
    else if (i_ce)
    begin
      wait_r <= ~(req & wait_r);
      if (rd_cap)
        rdata_r <= rd_mux;
      if (wr_take & hit_ctrl)
        ctrl_r <= be_merge(ctrl_r, i_avs_writedata, i_avs_byteenable) & CFS_CTRL_WMASK;
      if (wr_take & hit_txm)
        tx_mask_r <= be_merge(tx_mask_r, i_avs_writedata, i_avs_byteenable);
      if (wr_take & hit_rxm)
        rx_mask_r <= be_merge(rx_mask_r, i_avs_writedata, i_avs_byteenable);
    end
  end

  // ----------------------------------------
  // Buffers
  // ----------------------------------------
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_buf
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
      if (i_sys_rst)
      begin
        tx_buf_r[g] <= 16'h0000;
        rx_buf_r[g] <= 16'h0000;
      end
      else if (i_ce)
      begin
        if (wr_take & hit_txb & (buf_sel == PTR_W'(g)))
          tx_buf_r[g] <= be_merge(tx_buf_r[g], i_avs_writedata, i_avs_byteenable);
        if (slot_end & rx_en & (ptr_r == PTR_W'(g)))
          rx_buf_r[g] <= rx_just;
      end
    end
  end

  // ----------------------------------------
  // Frame state and counters
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= CFS_ST_IDLE;
      bit_cnt_r <= 4'h0;
      slot_cnt_r <= 4'h0;
      ptr_r <= '0;
      fs_prev_r <= 1'b0;
      rx_sh_r <= 16'h0000;
    end
    else if (samp_edge)
    begin
      fs_prev_r <= fs_src;
      ptr_r <= ptr_nxt;
      case (st_r)
        CFS_ST_IDLE:
          if (start & ~frame_end)
            st_r <= CFS_ST_RUN;
        CFS_ST_RUN:
          if (frame_end)
            st_r <= CFS_ST_IDLE;
        default:
          st_r <= CFS_ST_IDLE;
      endcase
      if (bit_take)
      begin
        rx_sh_r <= rx_word;
        bit_cnt_r <= slot_end ? 4'h0 : 4'(cnt_eff + 4'h1);
        slot_cnt_r <= frame_end ? 4'h0 : (slot_end ? slot_nxt : slot_eff);
      end
      else if (start)
      begin
        bit_cnt_r <= 4'h0;
        slot_cnt_r <= 4'h0;
      end
    end
  end

  // ----------------------------------------
  // Transmit shifter and pins
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_sh_r <= 16'h0000;
      link_r <= '0;
    end
    else if (i_ce)
    begin
      link_r.frame_sync_oe <= ctrl_r.master & ctrl_r.enable;
      if (tx_load)
        tx_sh_r <= tx_word;
      else if (drv_edge & run)
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      if (drv_edge)
      begin
        link_r.serial_data_out <= run & tx_en & tx_sh_r[15];
        link_r.serial_data_oe <= (run & tx_en) | ~ctrl_r.idle_slot_drive_mode;
        if (is_i2s)
          link_r.frame_sync_pin <= fs_gen_set ? ~link_r.frame_sync_pin : link_r.frame_sync_pin;
        else
          link_r.frame_sync_pin <= fs_gen_set & ~link_r.frame_sync_pin;
      end
      if (just_start)
      begin
        link_r.serial_data_out <= next_en & tx_word[15];
        link_r.serial_data_oe <= next_en | ~ctrl_r.idle_slot_drive_mode;
      end
    end
  end

  assign o_link = link_r;
  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_start_enters_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (start & ~frame_end) |=> (st_r == CFS_ST_RUN && slot_cnt_r == 4'h0))
    else $error("frame start did not enter run");
  chk_sync_ignored_in_frame: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run & samp_edge & fs_seen & ~frame_end) |=> (st_r == CFS_ST_RUN))
    else $error("sync restarted a running frame");
  chk_frame_end_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run & frame_end) |=> (st_r == CFS_ST_IDLE && slot_cnt_r == 4'h0 && bit_cnt_r == 4'h0))
    else $error("frame did not end after last slot");
  chk_ptr_advance: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ptr_adv & (ptr_r != PTR_LAST)) |=> (ptr_r == PTR_W'($past(ptr_r) + 1'b1)))
    else $error("pointer did not advance on enabled slot");
  chk_ptr_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (slot_end & ~tx_en & ~rx_en) |=> $stable(ptr_r))
    else $error("pointer moved on disabled slot");
  chk_rx_store_word: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (slot_end & rx_en) |=> (rx_buf_r[$past(ptr_r)] == $past(rx_just)))
    else $error("received word not stored left-justified");
  chk_idle_slot_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (drv_edge & run & ~tx_en & ~ctrl_r.idle_slot_drive_mode & ~tx_load) |=>
      (!o_link.serial_data_out && o_link.serial_data_oe))
    else $error("disabled slot not driven low");
  chk_idle_slot_float: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (drv_edge & run & ~tx_en & ctrl_r.idle_slot_drive_mode & ~tx_load) |=> !o_link.serial_data_oe)
    else $error("disabled slot not released");
  chk_bit_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (bit_take & ~slot_end) |=> (bit_cnt_r == 4'($past(cnt_eff) + 4'h1)))
    else $error("slot bit counter skipped");
  chk_sample_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (samp_edge & run) |-> (sck_q2 == ctrl_r.sample_edge_select))
    else $error("data sampled on wrong clock edge");
  chk_bus_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce & req & wait_r) |=> (!o_avs_waitrequest ##1 o_avs_waitrequest))
    else $error("bus answer not one cycle");
  chk_sync_drive_master: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce |=> (o_link.frame_sync_oe == $past(ctrl_r.master & ctrl_r.enable)))
    else $error("sync pin drive does not follow master mode");
  chk_idle_holds_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (~run & samp_edge & ~start) |=> (st_r == CFS_ST_IDLE && $stable(slot_cnt_r) && $stable(ptr_r)))
    else $error("idle frame logic moved without sync");
  chk_tx_msb_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (drv_edge & run & tx_en) |=> (o_link.serial_data_out == $past(tx_sh_r[15])))
    else $error("transmit bit not taken from shifter top");
  chk_justify_first_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (just_start & (ws != 4'h0)) |=> (run && bit_cnt_r == 4'h1))
    else $error("justified frame did not take its first bit");

  cov_multi_frame: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    (run & frame_end & (ctrl_r.format == CFS_FMT_MULTI)));
  cov_i2s_start: cover property (@(posedge i_clk) disable iff (i_sys_rst) (start & is_i2s));
  cov_aclink_start: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    (start & (ctrl_r.format == CFS_FMT_ACLINK)));
  cov_justified_store: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    (just_start ##[1:200] (slot_end & rx_en)));

endmodule

// [design/cfs_pkg.sv]
// Constants, register map and carrier types for the codec frame/slot interface.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one word per register.
package cfs_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CFS_OFS_CTRL = 8'h00;
  localparam logic [7:0] CFS_OFS_TX_SLOT = 8'h04;
  localparam logic [7:0] CFS_OFS_RX_SLOT = 8'h08;
  localparam logic [7:0] CFS_OFS_STATUS = 8'h0C;
  localparam logic [1:0] CFS_TXBUF_REGION = 2'h1;
  localparam logic [1:0] CFS_RXBUF_REGION = 2'h2;

  // ----------------------------------------
  // Reset values and field limits
  // ----------------------------------------
  localparam logic [15:0] CFS_CTRL_RST = 16'h0000;
  localparam logic [15:0] CFS_SLOT_RST = 16'h0000;
  localparam logic [15:0] CFS_CTRL_WMASK = 16'hFF7F;
  localparam logic [3:0] CFS_WS_MAX = 4'hF;

  // ----------------------------------------
  // Frame formats
  // ----------------------------------------
  localparam logic [1:0] CFS_FMT_MULTI = 2'h0;
  localparam logic [1:0] CFS_FMT_I2S = 2'h1;
  localparam logic [1:0] CFS_FMT_ACLINK = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CFS_ST_IDLE = 2'b01,
    CFS_ST_RUN = 2'b10
  } cfs_state_t;

  typedef struct packed {
    logic [3:0] frame_length_sel;
    logic [3:0] word_size_sel;
    logic rsvd;
    logic idle_slot_drive_mode;
    logic justify_same_cycle;
    logic sample_edge_select;
    logic [1:0] format;
    logic master;
    logic enable;
  } cfs_ctrl_t;

  typedef struct packed {
    logic frame_sync_pin;
    logic frame_sync_oe;
    logic serial_data_out;
    logic serial_data_oe;
  } cfs_link_out_t;

endpackage

// [verification/cfs_codec_model.sv]
// Behavioural codec at the far end of the serial link.
// Assumes the bench calls frame() and feeds the design's data pin and its enable back in.
`timescale 1ns/100ps
module cfs_codec_model
(
  // Link to the design
  output logic o_bit_clock,
  output logic o_frame_sync,
  output logic o_data,
  input wire logic i_data,
  input wire logic i_data_oe
);
  logic raw = 1'b0;
  logic inv = 1'b0;
  assign o_bit_clock = raw ^ inv;
  initial
  begin
    o_frame_sync = 1'b0;
    o_data = 1'b0;
  end
  // ----------------------------------------
  // One 32-bit frame, clock still outside it
  // ----------------------------------------
  // Opt bits: 0 invert clock, 1 toggle sync, 2 same-cycle data, 3 stray sync
  task automatic frame(input logic [31:0] rxv, input logic [3:0] opt, output logic [31:0] txv,
    output logic [31:0] oev);
    int d;
    inv = opt[0];
    #7;
    for (int k = 0; k <= 32; k++)
    begin
      raw = 1'b1;
      if (k == 0)
        o_frame_sync = opt[1] ? ~o_frame_sync : 1'b1;
      else if (!opt[1])
        o_frame_sync = opt[3] && k == 3;
      d = opt[2] ? k : k - 1;
      o_data = (d >= 0 && d < 32) ? rxv[31 - d] : ~o_data;
      #16 raw = 1'b0;
      #8;
      if (k >= 1)
      begin
        txv[32 - k] = i_data;
        oev[32 - k] = i_data_oe;
      end
      #8;
    end
  endtask
endmodule

// [verification/cfs_codec_frame_slot_tb.sv]
// Self-checking bench: Avalon-MM register tests, then four framed transfers.
// Assumes DEPTH of 4 and a codec model that runs 32-bit frames.
`timescale 1ns/100ps
module cfs_codec_frame_slot_tb
  import cfs_pkg::*;
;
  logic clk;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ben = 4'h0;
  logic [31:0] rdat;
  logic wreq;
  cfs_link_out_t lnk;
  logic bclk;
  logic fsync;
  logic sdi;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int ptr = 0;
  logic [31:0] exp_q[$];
  logic [15:0] txbuf[4];
  logic [15:0] rxmem[4] = '{default: 16'h0000};
  logic [1:0] fmt[4] = '{CFS_FMT_MULTI, CFS_FMT_ACLINK, CFS_FMT_MULTI, CFS_FMT_I2S};
  logic [3:0] ws[4] = '{4'hF, 4'h7, 4'h3, 4'hF};
  logic [3:0] fl[4] = '{4'h1, 4'h3, 4'h7, 4'h1};
  logic [15:0] txm[4] = '{16'h0001, 16'hFF0A, 16'h00A5, 16'h0003};
  logic [15:0] rxm[4] = '{16'h0002, 16'hF005, 16'h005A, 16'h0003};
  logic [3:0] opt[4] = '{4'h8, 4'h0, 4'h4, 4'h3};
  logic md[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  cfs_codec_frame_slot #(.DEPTH(4)) cfs_codec_frame_slot_i (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
    .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .i_avs_byteenable(ben), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_serial_bit_clock(bclk), .i_frame_sync_pin(fsync), .i_serial_data_in(sdi), .o_link(lnk));
  cfs_codec_model cfs_codec_model_i (.o_bit_clock(bclk), .o_frame_sync(fsync), .o_data(sdi),
    .i_data(lnk.serial_data_out), .i_data_oe(lnk.serial_data_oe));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
    @(posedge clk);
    adr <= a;
    wr_en <= w;
    rd_en <= ~w;
    wdat <= {16'h0000, d};
    ben <= be;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000, 4'hF);
  endtask
  // ----------------------------------------
  // Clock, watchdog and read monitor
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rd_en === 1'b1 && wreq === 1'b0)
      check(rdat, exp_q.pop_front(), "read data");
    if (cycles == 10000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    cfs_ctrl_t cfg;
    logic [31:0] rxv;
    logic [31:0] txv;
    logic [31:0] oev;
    logic [15:0] r;
    logic [15:0] rw;
    int i;
    void'($urandom(32'hB1C4AC30));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(CFS_OFS_CTRL, 32'h0);
    rd(CFS_OFS_TX_SLOT, 32'h0);
    rd(CFS_OFS_RX_SLOT, 32'h0);
    rd(CFS_OFS_STATUS, 32'h0);
    rd(8'hFC, 32'h0);
    rd(8'h50, 32'h0);
    bus(1'b1, CFS_OFS_CTRL, 16'hFFFF, 4'h3);
    rd(CFS_OFS_CTRL, {16'h0000, CFS_CTRL_WMASK});
    bus(1'b1, CFS_OFS_CTRL, 16'h0000, 4'h3);
    r = 16'($urandom);
    bus(1'b1, CFS_OFS_TX_SLOT, r, 4'h1);
    rd(CFS_OFS_TX_SLOT, {24'h0, r[7:0]});
    bus(1'b1, CFS_OFS_RX_SLOT, r, 4'h2);
    rd(CFS_OFS_RX_SLOT, {16'h0, r[15:8], 8'h00});
    bus(1'b1, CFS_OFS_STATUS, r, 4'h3);
    bus(1'b1, 8'h80, r, 4'h3);
    rd(CFS_OFS_STATUS, 32'h0);
    rd(8'h80, 32'h0);
    $display("test registers done");
    for (int n = 0; n < 4; n++)
    begin
      cfg = '0;
      cfg.enable = 1'b1;
      cfg.format = fmt[n];
      cfg.master = (n == 1);
      cfg.sample_edge_select = opt[n][0];
      cfg.justify_same_cycle = opt[n][2];
      cfg.idle_slot_drive_mode = md[n];
      cfg.word_size_sel = ws[n];
      cfg.frame_length_sel = fl[n];
      bus(1'b1, CFS_OFS_TX_SLOT, txm[n], 4'h3);
      bus(1'b1, CFS_OFS_RX_SLOT, rxm[n], 4'h3);
      for (i = 0; i < 4; i++)
      begin
        txbuf[i] = 16'($urandom);
        bus(1'b1, 8'h40 | 8'(4 * i), txbuf[i], 4'h3);
      end
      rd(8'h44, {16'h0, txbuf[1]});
      bus(1'b1, CFS_OFS_CTRL, cfg, 4'h3);
      rxv = $urandom;
      cfs_codec_model_i.frame(rxv, opt[n], txv, oev);
      check(32'(lnk.frame_sync_oe), 32'(n == 1), "sync drive");
      for (int s = 0; s <= int'(fl[n]); s++)
      begin
        rw = 16'h0000;
        for (int b = 0; b <= int'(ws[n]); b++)
        begin
          i = s * (int'(ws[n]) + 1) + b;
          if (!opt[n][2] && (!md[n] || txm[n][s]))
            check(32'(txv[31 - i]), 32'(txm[n][s] && txbuf[ptr][15 - b]), "tx bit");
          if (!opt[n][2])
            check(32'(oev[31 - i]), 32'(!md[n] || txm[n][s]), "tx drive");
          rw[15 - b] = rxv[31 - i];
        end
        if (rxm[n][s])
          rxmem[ptr] = rw;
        if (txm[n][s] || rxm[n][s])
          ptr = (ptr + 1) % 4;
      end
      repeat (8) @(posedge clk);
      for (i = 0; i < 4; i++)
        rd(8'h80 | 8'(4 * i), {16'h0, rxmem[i]});
      $display("test frame %0d done", n);
    end
    conclude();
  end
endmodule
